// ---- shared/rail_seq_pkg.sv ----
package rail_seq_pkg;
  // clock rate and timing figures
  localparam int unsigned clk_hz = 100_000_000; // core clock
  localparam int unsigned tick_us_cycles = clk_hz / 1_000_000; // 1 us tick
  localparam int unsigned wd_timeout_ms = 1600; // watchdog timeout
  localparam int unsigned pg_pulse_ms = 100; // reset pulse length
  localparam int unsigned us_per_ms = 1000; // unit change
  localparam int unsigned wd_timeout_us = wd_timeout_ms * us_per_ms;
  localparam int unsigned pg_pulse_us = pg_pulse_ms * us_per_ms;
  // strap codes: 0..3 enabled, 4 and 5 (two largest resistors) disable
  localparam logic [2:0] strap_wd_off_a = 3'h4; // lower disabling value
  localparam logic [2:0] strap_wd_off_b = 3'h5; // higher disabling value
  // rail enables travel together
  typedef struct packed {
    logic hv_buck; // high-voltage buck enable
    logic lv_buck; // low-voltage buck enable
    logic lv_linear; // low-voltage linear enable
    logic switch_drv; // backlight switch enable
  } rail_en_s;
  // monitored rail power-good levels
  typedef struct packed {
    logic intermediate_rail; // hv buck output good
    logic low_voltage_buck_out; // lv buck output good
    logic low_voltage_linear_reg; // lv linear output good
    logic always_on_regulator; // always-on output in regulation
  } rail_good_s;
  // sequencer states
  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_hv_up = 2'b01,
    st_lv_up = 2'b10,
    st_done = 2'b11
  } seq_state_e;
endpackage

// ---- logic/wd_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
// watchdog counter and power-good low pulse, advanced by a 1 us tick
module wd_timer #(
  parameter int unsigned timeout_us = rail_seq_pkg::wd_timeout_us,
  parameter int unsigned pulse_us = rail_seq_pkg::pg_pulse_us
) (
  input wire logic clock_in, // core clock
  input wire logic rst_in, // async reset, high
  input wire logic tick_in, // 1 us enable pulse
  input wire logic run_in, // watchdog active
  input wire logic kick_in, // clear pulse (rising edge seen)
  output logic expire_out // high during the reset pulse
);
  // refuse counts that the 21-bit and 17-bit counters cannot hold
  if (timeout_us < 2 || timeout_us > 32'h0020_0000 || pulse_us < 1 ||
      pulse_us > 32'h0001_ffff) begin
    $error("wd_timer: watchdog counts out of range");
  end
  logic [20:0] count; // elapsed microseconds
  logic [20:0] next_count;
  logic [16:0] pulse; // remaining pulse microseconds
  logic [16:0] next_pulse;
  logic next_expire;
  // next-state: count up, expire, then hold the pulse
  always_comb begin
    next_count = count;
    next_pulse = pulse;
    next_expire = expire_out;
    if (expire_out) begin
      // pulse running: finish it regardless of the clear input
      if (tick_in) begin
        if (pulse <= 17'h00001) begin
          next_expire = 1'b0;
          next_pulse = 17'h00000;
        end else begin
          next_pulse = pulse - 17'h00001;
        end
      end
      next_count = 21'h000000;
    end else if (!run_in || kick_in) begin
      next_count = 21'h000000;
    end else if (tick_in) begin
      if (count >= 21'(timeout_us - 1)) begin
        next_expire = 1'b1;
        next_pulse = 17'(pulse_us);
        next_count = 21'h000000;
      end else begin
        next_count = count + 21'h000001;
      end
    end
  end
  // registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      count <= 21'h000000;
      pulse <= 17'h00000;
      expire_out <= 1'b0;
    end else begin
      count <= next_count;
      pulse <= next_pulse;
      expire_out <= next_expire;
    end
  end
endmodule
`default_nettype wire

// ---- logic/rail_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
// How it works
// - watchdog clears on each clear-input rising edge
// - watchdog runs while wake or start high
// - expiry drives always-on power-good low
// - disabling strap settings keep watchdog off
// - sequence-ok low on failed sequence or bad rail
// - fault input low disables backlight switch driver
// - start high begins power-on sequence
// - start low runs power-off sequence
// - wake and start low: only always-on enabled
// - always-on regulator enabled above battery lockout
// - missed clear within 1600 ms gives 100 ms low
// - hv buck first, then rest, then ok
// - two largest strap values disable watchdog
// - hv buck fault drops downstream rails until recovery
module rail_sequencer #(
  parameter int unsigned timeout_us = rail_seq_pkg::wd_timeout_us,
  parameter int unsigned pulse_us = rail_seq_pkg::pg_pulse_us
) (
  input wire logic clock_in, // core clock, 100 MHz
  input wire logic rst_in, // async reset, high
  input wire logic wake_in, // wake pin
  input wire logic start_in, // start pin
  input wire logic watchdog_clear_in, // watchdog clear pin
  input wire logic fault_in_n, // backlight fault, low active
  input wire logic battery_ok_in, // battery above lockout
  input wire logic [2:0] freq_set_strap_in, // decoded strap code
  input wire rail_seq_pkg::rail_good_s good_in, // analog comparators
  output rail_seq_pkg::rail_en_s rail_en_out, // converter enables
  output logic always_on_en_out, // always-on regulator enable
  output logic always_on_power_good_out, // open-drain, 0 = drive low
  output logic always_on_power_good_oe_n_out, // low while pulling low
  output logic hv_buck_power_good_out, // open-drain level
  output logic hv_buck_power_good_oe_n_out, // low while pulling low
  output logic sequence_ok_out, // open-drain level
  output logic sequence_ok_oe_n_out, // low while pulling low
  output logic backlight_switch_drive_out, // high = sink current
  output logic low_quiescent_out, // low-current mode
  output logic watchdog_active_out // watchdog running
);
  // refuse counts that the watchdog counters cannot hold
  if (timeout_us < 2 || timeout_us > 32'h0020_0000 || pulse_us < 1 ||
      pulse_us > 32'h0001_ffff) begin
    $error("rail_sequencer: watchdog counts out of range");
  end

  // three-stage synchronisers for pins
  logic [2:0] wake_s, start_s, clear_s, fault_s, bat_s;
  logic [2:0] next_wake_s, next_start_s, next_clear_s, next_fault_s;
  logic [2:0] next_bat_s;
  logic [3:0] good_s1, good_s2, good_s3; // rail good chain
  logic wake, start, clr, fault_n, bat_ok; // filtered levels
  logic [3:0] good; // filtered rail good bits
  logic next_wake, next_start, next_clr, next_fault_n, next_bat_ok;
  logic [3:0] next_good;

  // filter: accept a new level once stages two and three agree
  function automatic logic agree(input logic [2:0] s, input logic cur);
    agree = (s[1] == s[2]) ? s[1] : cur;
  endfunction

  // synchroniser next values
  always_comb begin
    next_wake_s = {wake_s[1:0], wake_in};
    next_start_s = {start_s[1:0], start_in};
    next_clear_s = {clear_s[1:0], watchdog_clear_in};
    next_fault_s = {fault_s[1:0], fault_in_n};
    next_bat_s = {bat_s[1:0], battery_ok_in};
    next_wake = agree(wake_s, wake);
    next_start = agree(start_s, start);
    next_clr = agree(clear_s, clr);
    next_fault_n = agree(fault_s, fault_n);
    next_bat_ok = agree(bat_s, bat_ok);
    for (int i = 0; i < 4; i++) begin
      next_good[i] = (good_s2[i] == good_s3[i]) ? good_s2[i] : good[i];
    end
  end

  // synchroniser registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wake_s <= 3'h0;
      start_s <= 3'h0;
      clear_s <= 3'h0;
      fault_s <= 3'h0;
      bat_s <= 3'h0;
      good_s1 <= 4'h0;
      good_s2 <= 4'h0;
      good_s3 <= 4'h0;
      wake <= 1'b0;
      start <= 1'b0;
      clr <= 1'b0;
      fault_n <= 1'b0;
      bat_ok <= 1'b0;
      good <= 4'h0;
    end else begin
      wake_s <= next_wake_s;
      start_s <= next_start_s;
      clear_s <= next_clear_s;
      fault_s <= next_fault_s;
      bat_s <= next_bat_s;
      good_s1 <= good_in;
      good_s2 <= good_s1;
      good_s3 <= good_s2;
      wake <= next_wake;
      start <= next_start;
      clr <= next_clr;
      fault_n <= next_fault_n;
      bat_ok <= next_bat_ok;
      good <= next_good;
    end
  end

  // unpack the filtered rail good bits
  logic hv_good, lvb_good, lvl_good, ao_good;
  assign hv_good = good[3];
  assign lvb_good = good[2];
  assign lvl_good = good[1];
  assign ao_good = good[0];

  // 1 us tick divider
  logic [6:0] div; // cycle counter
  logic [6:0] next_div;
  logic tick; // one-cycle enable
  logic next_tick;
  always_comb begin
    next_tick = 1'b0;
    if (div >= 7'(rail_seq_pkg::tick_us_cycles - 1)) begin
      next_div = 7'h00;
      next_tick = 1'b1;
    end else begin
      next_div = div + 7'h01;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      div <= 7'h00;
      tick <= 1'b0;
    end else begin
      div <= next_div;
      tick <= next_tick;
    end
  end

  // strap capture: taken once after reset release
  logic [2:0] strap; // held strap code
  logic strap_taken; // capture done
  logic [2:0] next_strap;
  logic next_strap_taken;
  always_comb begin
    next_strap = strap;
    next_strap_taken = 1'b1;
    if (!strap_taken) begin
      next_strap = freq_set_strap_in;
    end
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      strap <= 3'h0;
      strap_taken <= 1'b0;
    end else begin
      strap <= next_strap;
      strap_taken <= next_strap_taken;
    end
  end

  // watchdog run condition and clear edge
  logic wd_off_strap, wd_run, clr_prev, next_clr_prev, kick, expire;
  assign wd_off_strap = (strap == rail_seq_pkg::strap_wd_off_a) ||
                        (strap == rail_seq_pkg::strap_wd_off_b);
  assign wd_run = (wake || start) && !wd_off_strap && strap_taken;
  assign kick = clr && !clr_prev;
  assign next_clr_prev = clr;
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      clr_prev <= 1'b0;
    end else begin
      clr_prev <= next_clr_prev;
    end
  end

  wd_timer #(
    .timeout_us(timeout_us),
    .pulse_us(pulse_us)
  ) u_wd (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tick_in(tick),
    .run_in(wd_run),
    .kick_in(kick),
    .expire_out(expire)
  );

  // power sequencer
  rail_seq_pkg::seq_state_e state, next_state;
  rail_seq_pkg::rail_en_s next_rail_en;
  logic next_seq_ok, next_ao_en, next_ao_pg, next_hv_pg, next_bl;
  logic next_lq, next_wd_act;
  always_comb begin
    next_state = state;
    unique case (state)
      rail_seq_pkg::st_off: begin
        if (start && bat_ok) begin
          next_state = rail_seq_pkg::st_hv_up;
        end
      end
      rail_seq_pkg::st_hv_up: begin
        if (hv_good) begin
          next_state = rail_seq_pkg::st_lv_up;
        end
      end
      rail_seq_pkg::st_lv_up: begin
        if (!hv_good) begin
          next_state = rail_seq_pkg::st_hv_up;
        end else if (lvb_good && lvl_good) begin
          next_state = rail_seq_pkg::st_done;
        end
      end
      rail_seq_pkg::st_done: begin
        if (!hv_good) begin
          next_state = rail_seq_pkg::st_hv_up;
        end
      end
    endcase
    if (!start || !bat_ok) begin
      next_state = rail_seq_pkg::st_off;
    end
    // enables follow the next state
    next_rail_en.hv_buck = (next_state != rail_seq_pkg::st_off);
    next_rail_en.lv_buck = (next_state == rail_seq_pkg::st_lv_up) ||
                           (next_state == rail_seq_pkg::st_done);
    next_rail_en.lv_linear = next_rail_en.lv_buck;
    next_rail_en.switch_drv = next_rail_en.lv_buck;
    next_bl = next_rail_en.switch_drv && fault_n;
    next_seq_ok = (next_state == rail_seq_pkg::st_done) &&
                  hv_good && lvb_good && lvl_good;
    next_ao_en = bat_ok;
    next_ao_pg = !expire && ao_good;
    next_hv_pg = hv_good;
    next_lq = !wake && !start;
    next_wd_act = wd_run;
  end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state <= rail_seq_pkg::st_off;
      rail_en_out <= '0;
      backlight_switch_drive_out <= 1'b0;
      sequence_ok_out <= 1'b0;
      sequence_ok_oe_n_out <= 1'b0;
      always_on_en_out <= 1'b0;
      always_on_power_good_out <= 1'b0;
      always_on_power_good_oe_n_out <= 1'b0;
      hv_buck_power_good_out <= 1'b0;
      hv_buck_power_good_oe_n_out <= 1'b0;
      low_quiescent_out <= 1'b1;
      watchdog_active_out <= 1'b0;
    end else begin
      state <= next_state;
      rail_en_out <= next_rail_en;
      backlight_switch_drive_out <= next_bl;
      sequence_ok_out <= next_seq_ok;
      sequence_ok_oe_n_out <= next_seq_ok;
      always_on_en_out <= next_ao_en;
      always_on_power_good_out <= next_ao_pg;
      always_on_power_good_oe_n_out <= next_ao_pg;
      hv_buck_power_good_out <= next_hv_pg;
      hv_buck_power_good_oe_n_out <= next_hv_pg;
      low_quiescent_out <= next_lq;
      watchdog_active_out <= next_wd_act;
    end
  end
endmodule
`default_nettype wire

// ---- tb/rail_sequencer_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// pin-level checks on the sequencer, attached by bind
module rail_sequencer_checker #(
  parameter int unsigned timeout_us = rail_seq_pkg::wd_timeout_us,
  parameter int unsigned pulse_us = rail_seq_pkg::pg_pulse_us
) (
  input wire logic clock_in, // core clock
  input wire logic rst_in, // async reset
  input wire logic wake_in, // wake pin
  input wire logic start_in, // start pin
  input wire logic watchdog_clear_in, // clear pin
  input wire logic fault_in_n, // fault, low active
  input wire logic battery_ok_in, // battery above lockout
  input wire logic [2:0] freq_set_strap_in, // strap code
  input wire rail_seq_pkg::rail_good_s good_in, // rail goods
  input wire rail_seq_pkg::rail_en_s rail_en_out, // rail enables
  input wire logic always_on_en_out, // always-on enable
  input wire logic always_on_power_good_out, // always-on good
  input wire logic sequence_ok_out, // sequence ok level
  input wire logic backlight_switch_drive_out, // switch drive
  input wire logic low_quiescent_out, // quiet mode
  input wire logic watchdog_active_out // watchdog running
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  localparam int unsigned cyc = rail_seq_pkg::tick_us_cycles;
  localparam int unsigned late = timeout_us * cyc + 2 * cyc;
  localparam int unsigned early = timeout_us * cyc - 2 * cyc;
  int unsigned wd_cnt; // cycles run since the last clear edge
  int unsigned next_wd_cnt;
  logic clear_d; // clear level one cycle back
  // restart the count on a clear edge, a stop or a reset pulse
  always_comb begin
    next_wd_cnt = wd_cnt + 1;
    if (!watchdog_active_out || !always_on_power_good_out ||
        (watchdog_clear_in && !clear_d)) begin
      next_wd_cnt = 0;
    end
  end
  // register the helper state
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      wd_cnt <= 0;
      clear_d <= 1'b0;
    end else begin
      wd_cnt <= next_wd_cnt;
      clear_d <= watchdog_clear_in;
    end
  end
  AST_AO_EN: assert property (battery_ok_in [*8] ##3 battery_ok_in
    |-> always_on_en_out) else $error("always-on enable missing");
  AST_FAULT: assert property (!fault_in_n [*8]
    |-> !backlight_switch_drive_out) else $error("switch driven in fault");
  AST_QUIET: assert property ((!wake_in && !start_in) [*8] ##3
    (!wake_in && !start_in) |-> low_quiescent_out && !watchdog_active_out
    && rail_en_out == 4'h0) else $error("not quiet with pins low");
  AST_STRAP: assert property (freq_set_strap_in >= 3'h4
    |-> !watchdog_active_out) else $error("watchdog runs on off strap");
  AST_START: assert property ((start_in && battery_ok_in) [*8] ##3
    start_in |-> rail_en_out.hv_buck) else $error("hv buck not started");
  AST_ORDER: assert property ((rail_en_out.lv_buck || sequence_ok_out)
    |-> rail_en_out.hv_buck && rail_en_out.lv_linear == rail_en_out.lv_buck)
    else $error("low rails ahead of hv buck");
  AST_HV_FAULT: assert property (!good_in.intermediate_rail [*8] ##3
    !good_in.intermediate_rail |-> !rail_en_out.lv_buck
    && !rail_en_out.switch_drv && !sequence_ok_out)
    else $error("downstream rails kept on hv fault");
  AST_SEQ_BAD: assert property (!good_in.low_voltage_buck_out [*8] ##3
    !good_in.low_voltage_buck_out |-> !sequence_ok_out)
    else $error("sequence ok with bad rail");
  AST_WD_LATE: assert property (wd_cnt <= late)
    else $error("watchdog expiry overdue");
  AST_WD_EARLY: assert property ($fell(always_on_power_good_out)
    && good_in.always_on_regulator && battery_ok_in |-> wd_cnt >= early)
    else $error("good pin dropped before timeout");
endmodule
bind rail_sequencer rail_sequencer_checker #(.timeout_us(timeout_us),
  .pulse_us(pulse_us)) chk (.clock_in(clock_in), .rst_in(rst_in),
  .wake_in(wake_in), .start_in(start_in),
  .watchdog_clear_in(watchdog_clear_in), .fault_in_n(fault_in_n),
  .battery_ok_in(battery_ok_in), .freq_set_strap_in(freq_set_strap_in),
  .good_in(good_in), .rail_en_out(rail_en_out),
  .always_on_en_out(always_on_en_out),
  .always_on_power_good_out(always_on_power_good_out),
  .sequence_ok_out(sequence_ok_out),
  .backlight_switch_drive_out(backlight_switch_drive_out),
  .low_quiescent_out(low_quiescent_out),
  .watchdog_active_out(watchdog_active_out));
`default_nettype wire

// ---- tb/mcu_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// local controller: held in reset by the good pin, kicks when healthy
module mcu_model (
  input wire logic clock_in, // core clock
  input wire logic reset_n_in, // always-on good pin, low resets
  input wire logic kick_en_in, // firmware healthy
  input wire logic wake_req_in, // wake request
  input wire logic start_req_in, // start request
  output logic wake_out, // wake pin drive
  output logic start_out, // start pin drive
  output logic watchdog_clear_out // clear pin drive
);
  logic [10:0] cnt; // position in the 20 us kick period
  logic [10:0] next_cnt;
  // wrap the period counter
  always_comb begin
    next_cnt = (cnt == 11'h7cf) ? 11'h000 : cnt + 11'h001;
  end
  // restart the period while the controller is in reset
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cnt <= 11'h000;
    end else begin
      cnt <= next_cnt;
    end
  end
  // 1 us high pulse at each period start, well inside the timeout
  assign watchdog_clear_out = reset_n_in && kick_en_in && cnt < 11'h064;
  assign wake_out = wake_req_in; // wake pin follows firmware
  assign start_out = start_req_in; // start pin follows firmware
endmodule
`default_nettype wire

// ---- tb/rail_sequencer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// sequencer bench: pin scenarios with the controller model attached
module rail_sequencer_tb;
  localparam int t_us = 50; // shortened watchdog timeout
  localparam int p_us = 10; // shortened reset pulse
  localparam int cyc = rail_seq_pkg::tick_us_cycles;
  logic clock_in, rst_in, wake_req, start_req, kick_en, fault_in_n, bat;
  logic [2:0] strap; // strap code
  rail_seq_pkg::rail_good_s good; // comparator levels
  rail_seq_pkg::rail_en_s en; // rail enables
  logic wake, start, clear, ao_en, ao_pg, ao_pg_oe_n, hv_pg, hv_pg_oe_n;
  logic seq_ok, seq_ok_oe_n, bl, lq, wd_act;
  int failures, n_checks;
  wire logic ao_pg_pin = ao_pg_oe_n ? 1'b1 : 1'b0; // pulled up unless sunk
  wire logic hv_pg_pin = hv_pg_oe_n ? 1'b1 : 1'b0;
  wire logic seq_ok_pin = seq_ok_oe_n ? 1'b1 : 1'b0;
  wire logic [3:0] flags = {lq, wd_act, seq_ok_pin, bl}; // status group
  wire logic [3:0] goods = {ao_en, ao_pg_pin, hv_pg_pin, seq_ok}; // goods
  mcu_model mcu (.clock_in(clock_in), .reset_n_in(ao_pg_pin),
    .kick_en_in(kick_en), .wake_req_in(wake_req), .start_req_in(start_req),
    .wake_out(wake), .start_out(start), .watchdog_clear_out(clear));
  rail_sequencer #(.timeout_us(t_us), .pulse_us(p_us)) uut (
    .clock_in(clock_in), .rst_in(rst_in), .wake_in(wake), .start_in(start),
    .watchdog_clear_in(clear), .fault_in_n(fault_in_n),
    .battery_ok_in(bat), .freq_set_strap_in(strap), .good_in(good),
    .rail_en_out(en), .always_on_en_out(ao_en),
    .always_on_power_good_out(ao_pg),
    .always_on_power_good_oe_n_out(ao_pg_oe_n),
    .hv_buck_power_good_out(hv_pg), .hv_buck_power_good_oe_n_out(hv_pg_oe_n),
    .sequence_ok_out(seq_ok), .sequence_ok_oe_n_out(seq_ok_oe_n),
    .backlight_switch_drive_out(bl), .low_quiescent_out(lq),
    .watchdog_active_out(wd_act));
  // compare and count
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // wait n cycles, ending where outputs are settled
  task automatic settle(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // verdict and end of run
  task automatic summarize;
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // free-running 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // hang guard well beyond the planned run
  initial begin
    repeat (60000) @(posedge clock_in);
    failures++;
    summarize();
  end
  // scenarios
  initial begin
    int n;
    int m;
    rst_in = 1'b1;
    {wake_req, start_req, kick_en, fault_in_n, bat} = 5'h07;
    strap = 3'h0;
    good = 4'h1;
    failures = 0;
    n_checks = 0;
    repeat (12) @(posedge clock_in);
    rst_in <= 1'b0;
    settle(20);
    check(en, 4'h0);
    check(flags, 4'h8);
    check(goods, 4'hc);
    @(posedge clock_in);
    start_req <= 1'b1;
    settle(12);
    check(en, 4'h8);
    check(flags, 4'h4);
    @(posedge clock_in);
    good.intermediate_rail <= 1'b1;
    settle(12);
    check(en, 4'hf);
    check(flags, 4'h5);
    check(goods, 4'he);
    check({ao_pg, hv_pg, seq_ok_oe_n, seq_ok}, 4'hc);
    @(posedge clock_in);
    good <= 4'hf;
    settle(12);
    check(flags, 4'h7);
    check(goods, 4'hf);
    @(posedge clock_in);
    good.low_voltage_buck_out <= 1'b0;
    settle(12);
    check(flags, 4'h5);
    @(posedge clock_in);
    good <= 4'hf;
    fault_in_n <= 1'b0; // held low as an unused input would be
    settle(12);
    check(flags, 4'h6);
    @(posedge clock_in);
    fault_in_n <= 1'b1;
    good.intermediate_rail <= 1'b0;
    settle(12);
    check(en, 4'h8);
    check(flags, 4'h4);
    @(posedge clock_in);
    good.intermediate_rail <= 1'b1;
    settle(12);
    check(flags, 4'h7);
    @(posedge clock_in);
    start_req <= 1'b0;
    wake_req <= 1'b1;
    settle(12);
    check(en, 4'h0);
    check(flags, 4'h4);
    repeat (80) begin
      settle(100);
      check({3'h0, ao_pg_pin}, 4'h1);
    end
    @(posedge clear);
    n = 0;
    while (ao_pg_pin === 1'b1 && n < 6000) begin
      @(posedge clock_in);
      if (n == 200) kick_en <= 1'b0;
      @(negedge clock_in);
      n++;
    end
    check({3'h0, n >= t_us * cyc - cyc && n <= t_us * cyc + 2 * cyc},
      4'h1);
    m = 0;
    while (ao_pg_pin === 1'b0 && m < 2000) begin
      settle(1);
      m++;
    end
    check({3'h0, m >= p_us * cyc - cyc && m <= p_us * cyc + cyc},
      4'h1);
    @(posedge clock_in);
    kick_en <= 1'b1;
    bat <= 1'b0;
    start_req <= 1'b1; // start without battery is refused
    settle(12);
    check({3'h0, ao_en}, 4'h0);
    check(en, 4'h0);
    for (int c = 3; c < 6; c++) begin
      @(posedge clock_in);
      rst_in <= 1'b1;
      bat <= 1'b1;
      strap <= 3'(c);
      kick_en <= 1'b0;
      settle(3);
      @(posedge clock_in);
      rst_in <= 1'b0;
      settle(20);
      check({3'h0, wd_act}, (c < 4) ? 4'h1 : 4'h0);
      repeat ((c < 4) ? 0 : 60) begin
        settle(100);
        check({2'h0, wd_act, ao_pg_pin}, 4'h1);
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
